/* logic/smc_cfg.svh */
// Offsets, field positions, reset values and cycle counts of the sleep
// mode controller. Definitions only; included by the delay, controller and bench modules.
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// Wishbone byte offsets
`define SMC_ADR_POWER_CTRL  8'h00
`define SMC_ADR_STATUS      8'h04

// Power control register fields and reset value
`define SMC_ARM_BIT         7
`define SMC_SEL_HI          6
`define SMC_SEL_LO          4
`define SMC_SENSE1_HI       3
`define SMC_SENSE1_LO       2
`define SMC_SENSE0_HI       1
`define SMC_SENSE0_LO       0
`define SMC_POWER_CTRL_RST  8'h00
`define SMC_SENSE_LEVEL     2'h0

// Status register fields
`define SMC_ST_STATE_HI     3
`define SMC_ST_STATE_LO     0
`define SMC_ST_MODE_HI      6
`define SMC_ST_MODE_LO      4
`define SMC_ST_WOKE_RST     7
`define SMC_ST_XTAL_OK      8

// Clock source select ranges
`define SMC_CLOCK_SOURCE_SELECT_RC_MIN    4'h5
`define SMC_CLOCK_SOURCE_SELECT_RC_MAX    4'h8
`define SMC_CLOCK_SOURCE_SELECT_XTAL_MIN  4'h9
`define SMC_SUT_FAST        2'h3

// Cycle counts
`define SMC_HOLD_CYC        16'h0004
`define SMC_SU_STANDBY      16'h0006
`define SMC_SU_SHORT        16'h0006
`define SMC_SU_RC_LONG      16'h0012
`define SMC_SU_XTAL         16'h0400
`define SMC_SU_NONE         16'h0000

`endif

/* logic/smc_pkg.sv */
// Types shared by the sleep mode controller modules.
// Assumes smc_cfg.svh is on the include path.
package smc_pkg;

	typedef enum logic [3:0] {
		ST_RUN   = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_START = 4'b0100,
		ST_HOLD  = 4'b1000
	} smc_state_t;

	typedef enum logic [2:0] {
		MODE_IDLE        = 3'h0,
		MODE_ADC_NR      = 3'h1,
		MODE_PWR_DOWN    = 3'h2,
		MODE_PWR_SAVE    = 3'h3,
		MODE_RSVD4       = 3'h4,
		MODE_RSVD5       = 3'h5,
		MODE_STANDBY     = 3'h6,
		MODE_EXT_STANDBY = 3'h7
	} smc_mode_t;

	typedef struct packed {
		logic core_clock;
		logic program_mem_clock;
		logic peripheral_clock;
		logic adc_clock;
		logic async_clock;
		logic main_osc;
		logic timer_osc;
	} smc_clk_en_t;

	typedef struct packed {
		logic ext0_pend;
		logic ext1_pend;
		logic ext2_pend;
		logic twi_match;
		logic async_timer;
		logic nvm_ready;
		logic adc_done;
		logic other_io;
	} smc_wake_t;

endpackage

/* logic/smc_delay.sv */
// Loadable down counter timing start-up and core hold periods.
// Assumes the loader gives a value of one or more.
`timescale 1ns/100ps
`include "smc_cfg.svh"

module smc_delay (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	output logic             last
);
	logic [15:0] count;

	// Last cycle of the period: loaded N gives N cycles
	assign last = (count == 16'h0001);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			count <= 16'h0000;
		else if (load)
			count <= load_val;
		else if (count != 16'h0000)
			count <= count - 16'h0001;
	end
endmodule

/* logic/smc_ctrl.sv */
// Sleep mode controller: power control register on Wishbone, sleep entry,
// per-mode clock gating, wake detection, start-up and core hold timing.
// Assumes sleep_exec, wake_irq and reset_req come from logic on ref_clk;
// external interrupt pins are asynchronous.
`timescale 1ns/100ps
`include "smc_cfg.svh"

// Function
// RULE1 - Sleep is entered only if sleep arm is set when sleep executes.
// RULE2 - Three-bit select picks idle, noise reduction, down, save, standbys.
// RULE3 - Standby modes only accepted with an external crystal clock source.
// RULE4 - Interrupt wake holds core four cycles beyond start-up, then resumes.
// RULE5 - Register file and static memory keep contents across sleep.
// RULE6 - Reset during sleep wakes the core to restart from reset vector.
// RULE7 - Software sets arm just before sleep and clears it after waking.
// RULE8 - Idle stops only core and program memory clocks.
// RULE9 - Idle wakes on external and internal interrupts.
// RULE10 - Entering idle or noise reduction starts a conversion if enabled.
// RULE11 - Noise reduction stops peripheral, core and program memory clocks.
// RULE12 - Noise reduction wakes only on the listed sources.
// RULE13 - Power-down stops oscillator and all generated clocks.
// RULE14 - Power-down wakes on resets, address match, level or line 2 irq.
// RULE15 - A level wake must be held long enough to be seen.
// RULE16 - Power-down wake waits a start-up set by clock source selection.
// RULE17 - Power-save adds asynchronous timer wake when enabled globally.
// RULE18 - Power-save halts every clock except the async clock domain.
// RULE19 - Without async timer clocking software should prefer power-down.
// RULE20 - Standby is power-down with oscillator running, six cycle wake.
// RULE21 - Extended standby is power-save with oscillator, six cycle wake.
// RULE22 - With sleep arm clear, sleep is a no-operation.
module smc_ctrl import smc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        sleep_exec,
	input  wire logic [3:0]  clock_source_select,
	input  wire logic [1:0]  startup_time_sel,
	input  wire logic        async_timer_clock_sel,
	input  wire logic        global_irq_en,
	input  wire logic        adc_enabled,
	input  wire logic [2:0]  ext_irq_pin,
	input  wire logic [2:0]  ext_irq_en,
	input  wire smc_wake_t   wake_irq,
	input  wire logic        reset_req,
	output smc_clk_en_t      clk_en,
	output logic             core_resume,
	output logic             restart_vector,
	output logic             adc_auto_start
);
	// ****************************************************
	// Register bus
	// ****************************************************
	logic [7:0]  mcu_power_control;
	smc_state_t  state;
	smc_state_t  next_state;
	smc_mode_t   cur_mode;
	logic        woke_rst;
	wire         bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire         hit_ctrl = (wb_adr_i == `SMC_ADR_POWER_CTRL);
	wire         hit_stat = (wb_adr_i == `SMC_ADR_STATUS);
	wire         ctrl_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i &
		hit_ctrl & wb_sel_i[0];
	wire         sleep_arm = mcu_power_control[`SMC_ARM_BIT];
	wire [2:0]   sleep_select =
		mcu_power_control[`SMC_SEL_HI:`SMC_SEL_LO];
	wire         xtal_ok = (clock_source_select >= `SMC_CLOCK_SOURCE_SELECT_XTAL_MIN);
	wire [31:0]  status_word = {23'h000000, xtal_ok, woke_rst,
		cur_mode, state};
	wire [31:0]  rd_word = hit_ctrl ? {24'h000000, mcu_power_control} :
		hit_stat ? status_word : 32'h00000000;

	// Unmapped addresses still ack, reading zero and ignoring writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req)
				wb_dat_o <= rd_word;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			mcu_power_control <= `SMC_POWER_CTRL_RST;
		else if (ctrl_wr)
			mcu_power_control <= wb_dat_i[7:0];
	end

	// ****************************************************
	// External interrupt pins
	// ****************************************************
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;

	// A short level pulse can vanish between synchroniser samples [RULE15]
	for (genvar g = 0; g < 3; g++) begin : g_pin
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				pin_meta[g] <= 1'b1;
				pin_sync[g] <= 1'b1;
			end else begin
				pin_meta[g] <= ext_irq_pin[g];
				pin_sync[g] <= pin_meta[g];
			end
		end
	end

	wire sense0_lvl = (mcu_power_control[`SMC_SENSE0_HI:`SMC_SENSE0_LO]
		== `SMC_SENSE_LEVEL);
	wire sense1_lvl = (mcu_power_control[`SMC_SENSE1_HI:`SMC_SENSE1_LO]
		== `SMC_SENSE_LEVEL);
	wire lvl0_wake = ~pin_sync[0] & ext_irq_en[0] & sense0_lvl;
	wire lvl1_wake = ~pin_sync[1] & ext_irq_en[1] & sense1_lvl;

	// ****************************************************
	// Mode decode and wake sources
	// ****************************************************
	wire mode_valid = (sleep_select != MODE_RSVD4) &&
		(sleep_select != MODE_RSVD5); // [RULE2]
	wire mode_needs_xtal = (sleep_select == MODE_STANDBY) ||
		(sleep_select == MODE_EXT_STANDBY);
	wire mode_ok = mode_valid & (~mode_needs_xtal | xtal_ok); // [RULE3]
	// Arm bit is sampled with the sleep strobe only [RULE1] [RULE7] [RULE22]
	wire enter = (state == ST_RUN) & sleep_exec & sleep_arm & mode_ok;

	wire deep_wake = wake_irq.twi_match | lvl0_wake | lvl1_wake |
		wake_irq.ext2_pend; // [RULE14]
	wire async_wake = wake_irq.async_timer & async_timer_clock_sel &
		global_irq_en; // [RULE17]
	wire idle_wake = (|wake_irq) | lvl0_wake | lvl1_wake; // [RULE9]
	wire adcnr_wake = deep_wake | wake_irq.adc_done | async_wake |
		wake_irq.nvm_ready; // [RULE12]

	logic irq_wake;
	always_comb begin
		case (cur_mode)
			MODE_IDLE:        irq_wake = idle_wake;
			MODE_ADC_NR:      irq_wake = adcnr_wake;
			MODE_PWR_DOWN:    irq_wake = deep_wake;
			MODE_STANDBY:     irq_wake = deep_wake;
			MODE_PWR_SAVE:    irq_wake = deep_wake | async_wake;
			MODE_EXT_STANDBY: irq_wake = deep_wake | async_wake;
			default:          irq_wake = 1'b1;
		endcase
	end

	// ****************************************************
	// Clock gating per mode
	// ****************************************************
	// Gating only stops clocks; no storage is cleared on the way [RULE5]
	function automatic smc_clk_en_t sleep_clocks(input logic [2:0] m,
		input logic asy);
		smc_clk_en_t c;
		// Bits in struct order: core clock first, timer oscillator last
		case (m)
			MODE_IDLE:        c = {5'b00111, 1'b1, asy}; // [RULE8]
			MODE_ADC_NR:      c = {5'b00011, 1'b1, asy}; // [RULE11]
			MODE_PWR_SAVE:    c = {4'b0000, asy, 1'b0, asy}; // [RULE18]
			MODE_STANDBY:     c = 7'h02; // [RULE20]
			MODE_EXT_STANDBY: c = {4'b0000, asy, 1'b1, asy}; // [RULE21]
			default:          c = '0; // [RULE13]
		endcase
		return c;
	endfunction

	// Start-up length follows the clock source selection [RULE16]
	function automatic logic [15:0] startup_len(input logic [2:0] m,
		input logic [3:0] cks, input logic [1:0] sut);
		logic [15:0] n;
		n = `SMC_SU_SHORT;
		if (m == MODE_IDLE || m == MODE_ADC_NR)
			n = `SMC_SU_NONE;
		else if (m == MODE_STANDBY || m == MODE_EXT_STANDBY)
			n = `SMC_SU_STANDBY; // [RULE20] [RULE21]
		else if (cks >= `SMC_CLOCK_SOURCE_SELECT_XTAL_MIN)
			n = `SMC_SU_XTAL;
		else if (cks >= `SMC_CLOCK_SOURCE_SELECT_RC_MIN && cks <= `SMC_CLOCK_SOURCE_SELECT_RC_MAX &&
			sut != `SMC_SUT_FAST)
			n = `SMC_SU_RC_LONG;
		return n;
	endfunction

	smc_clk_en_t run_clocks;
	always_comb begin
		run_clocks = '1;
		run_clocks.timer_osc = async_timer_clock_sel;
	end

	// ****************************************************
	// Sequencer
	// ****************************************************
	wire         wake = reset_req | irq_wake; // [RULE6]
	wire [15:0]  su_len = startup_len(cur_mode, clock_source_select,
		startup_time_sel);
	wire         dly_last;
	wire         go_start = (state == ST_SLEEP) & wake &
		(su_len != `SMC_SU_NONE);
	wire         go_hold = ((state == ST_SLEEP) & wake &
		(su_len == `SMC_SU_NONE)) | ((state == ST_START) & dly_last);
	wire         dly_load = go_start | go_hold;
	wire [15:0]  dly_val = go_start ? su_len : `SMC_HOLD_CYC; // [RULE4]
	wire         leave = (state == ST_HOLD) & dly_last;

	always_comb begin
		case (state)
			ST_RUN:   next_state = enter ? ST_SLEEP : ST_RUN;
			ST_SLEEP: next_state = go_start ? ST_START :
				go_hold ? ST_HOLD : ST_SLEEP;
			ST_START: next_state = dly_last ? ST_HOLD : ST_START;
			ST_HOLD:  next_state = dly_last ? ST_RUN : ST_HOLD;
			default:  next_state = ST_RUN;
		endcase
	end

	smc_clk_en_t next_clk_en;
	always_comb begin
		case (next_state)
			ST_RUN:   next_clk_en = run_clocks;
			ST_SLEEP: next_clk_en = enter ?
				sleep_clocks(sleep_select, async_timer_clock_sel) : clk_en;
			ST_START: begin
				next_clk_en = clk_en;
				next_clk_en.main_osc = 1'b1;
			end
			ST_HOLD: begin
				next_clk_en = run_clocks; // Core stays halted [RULE4]
				next_clk_en.core_clock = 1'b0;
			end
			default:  next_clk_en = run_clocks;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_RUN;
			cur_mode <= MODE_IDLE;
			woke_rst <= 1'b0;
			clk_en <= '1;
			core_resume <= 1'b0;
			restart_vector <= 1'b0;
			adc_auto_start <= 1'b0;
		end else begin
			state <= next_state;
			clk_en <= next_clk_en;
			if (enter) begin
				cur_mode <= smc_mode_t'(sleep_select);
				woke_rst <= 1'b0;
			end else if (state == ST_SLEEP && reset_req)
				woke_rst <= 1'b1;
			core_resume <= leave & ~woke_rst; // [RULE4]
			restart_vector <= leave & woke_rst; // [RULE6]
			adc_auto_start <= enter & adc_enabled &
				(sleep_select == MODE_IDLE ||
				sleep_select == MODE_ADC_NR); // [RULE10]
		end
	end

	smc_delay u_delay (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.load     (dly_load),
		.load_val (dly_val),
		.last     (dly_last)
	);

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_hold4;
		(state == ST_HOLD)[*4] ##1 (state == ST_RUN);
	endsequence
	sequence s_resumed;
		core_resume || restart_vector;
	endsequence

	chk_arm_gates_entry: assert property ( // [RULE1]
		(state == ST_RUN) && sleep_exec && !sleep_arm |=> state == ST_RUN)
		else $error("sleep entered with arm clear");
	chk_nop_keeps_clocks: assert property ( // [RULE22]
		(state == ST_RUN) && sleep_exec && !sleep_arm |=> clk_en.core_clock)
		else $error("core clock stopped on unarmed sleep");
	chk_reserved_refused: assert property ( // [RULE2]
		(state == ST_RUN) && sleep_exec && !mode_valid |=> state == ST_RUN)
		else $error("reserved sleep code accepted");
	chk_standby_xtal: assert property ( // [RULE3]
		(state == ST_SLEEP) && (cur_mode == MODE_STANDBY ||
		cur_mode == MODE_EXT_STANDBY) |-> xtal_ok)
		else $error("standby without crystal source");
	chk_hold_four_cycles: assert property ( // [RULE4]
		(state != ST_HOLD) ##1 (state == ST_HOLD) |-> s_hold4 ##0 s_resumed)
		else $error("core hold not four cycles");
	chk_idle_clocks: assert property ( // [RULE8]
		(state == ST_SLEEP) && (cur_mode == MODE_IDLE) |->
		!clk_en.core_clock && !clk_en.program_mem_clock &&
		clk_en.peripheral_clock && clk_en.adc_clock)
		else $error("idle clock set wrong");
	chk_adc_autostart: assert property ( // [RULE10]
		enter && adc_enabled && (sleep_select == MODE_ADC_NR) |=>
		adc_auto_start && (state == ST_SLEEP))
		else $error("conversion not started on entry");
	chk_noise_red_clocks: assert property ( // [RULE11]
		(state == ST_SLEEP) && (cur_mode == MODE_ADC_NR) |->
		!clk_en.peripheral_clock && !clk_en.core_clock && clk_en.adc_clock)
		else $error("noise reduction clock set wrong");
	chk_pwr_down_clocks: assert property ( // [RULE13]
		(state == ST_SLEEP) && (cur_mode == MODE_PWR_DOWN) |->
		clk_en == '0)
		else $error("clock running in power-down");
	chk_standby_wake_six: assert property ( // [RULE20]
		(state == ST_SLEEP) && (cur_mode == MODE_STANDBY) && wake |=>
		(state == ST_START)[*6] ##1 (state == ST_HOLD))
		else $error("standby start-up not six cycles");
	// A crystal start-up is too long for a delay range, so count instead
	logic [10:0] rst_wait;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rst_wait <= 11'h000;
		else if (restart_vector)
			rst_wait <= 11'h000;
		else if (|rst_wait || (state == ST_SLEEP && reset_req))
			rst_wait <= rst_wait + 11'h001;
	end
	chk_reset_restart: assert property ( // [RULE6]
		rst_wait != 11'h44c)
		else $error("reset wake did not restart");
endmodule

/* tb/smc_core_model.sv */
// Processor core stand-in for the sleep mode controller bench.
// Assumes one clock; issues one sleep pulse per request, counts wake pulses.
`timescale 1ns/100ps

module smc_core_model (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic do_sleep,
	input  wire logic core_resume,
	input  wire logic restart_vector,
	output logic      sleep_exec,
	output int        resumes,
	output int        restarts
);
	// Sleep is a single instruction, so never two pulses in a row
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sleep_exec <= 1'b0;
			resumes    <= 0;
			restarts   <= 0;
		end else begin
			sleep_exec <= do_sleep & ~sleep_exec;
			resumes    <= resumes + int'(core_resume);
			restarts   <= restarts + int'(restart_vector);
		end
	end
endmodule

/* tb/tb.sv */
// Self-checking bench of the sleep mode controller.
// Assumes smc_cfg.svh on the include path and the core model beside it.
`timescale 1ns/100ps
`include "smc_cfg.svh"

module tb import smc_pkg::*;;
	logic        ref_clk = 0, rst = 1, do_sleep = 0, sleep_exec;
	logic        wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
	logic [7:0]  wb_adr = 0;
	logic [3:0]  wb_sel = 0, cks = 4'h9;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic [1:0]  sut = 0;
	logic        asy = 0, gie = 0, adc_en = 1, reset_req = 0;
	logic [2:0]  pin = 3'h7, pen = 3'h0;
	smc_wake_t   wake = '0;
	smc_clk_en_t clk_en;
	logic        core_resume, restart_vector, adc_auto_start;
	int          resumes, restarts, err_total = 0, compares = 0;
	int          seed = 32'h1c4aaca4, n_adc = 0, na, base, d, h, n;

	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (adc_auto_start === 1'b1) n_adc++;

	smc_ctrl dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack), .sleep_exec(sleep_exec),
		.clock_source_select(cks), .startup_time_sel(sut),
		.async_timer_clock_sel(asy), .global_irq_en(gie),
		.adc_enabled(adc_en), .ext_irq_pin(pin), .ext_irq_en(pen),
		.wake_irq(wake), .reset_req(reset_req), .clk_en(clk_en),
		.core_resume(core_resume), .restart_vector(restart_vector),
		.adc_auto_start(adc_auto_start));

	smc_core_model core (.ref_clk(ref_clk), .rst(rst), .do_sleep(do_sleep),
		.core_resume(core_resume), .restart_vector(restart_vector),
		.sleep_exec(sleep_exec), .resumes(resumes), .restarts(restarts));

	task automatic chk(input logic [31:0] got, exp, input string msg);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] dt, input logic [3:0] s);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_i <= dt;
		wb_sel <= s;
		@(posedge ref_clk);
		// No local limit: only the watchdog ends a wait for ack
		while (wb_ack !== 1'b1)
			@(posedge ref_clk);
		chk(wb_ack, 1, "bus ack");
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Clocks left running in each mode, field order of smc_clk_en_t
	function automatic logic [6:0] exp_clk(input logic [2:0] m, input logic a);
		case (m)
			3'h0: return {5'b00111, 1'b1, a};
			3'h1: return {5'b00011, 1'b1, a};
			3'h2: return 7'h00;
			3'h3: return {4'b0000, a, 1'b0, a};
			3'h6: return 7'h02;
			3'h7: return {4'b0000, a, 1'b1, a};
			default: return {6'h3f, a};
		endcase
	endfunction

	task automatic sleep_in(input logic [2:0] m, input logic arm);
		wb(1, `SMC_ADR_POWER_CTRL, {24'h0, arm, m, 4'h0}, 4'h1);
		do_sleep <= 1'b1;
		@(posedge ref_clk);
		do_sleep <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// d: edges until the core hold shows, h: hold edges until resume
	task automatic meas();
		d = 0;
		h = 0;
		while (!(clk_en.core_clock === 1'b0
			&& clk_en.program_mem_clock === 1'b1) && d < 3000) begin
			@(posedge ref_clk);
			d++;
		end
		while (core_resume !== 1'b1 && h < 20) begin
			@(posedge ref_clk);
			h++;
		end
		wake <= '0;
		pin <= 3'h7;
		pen <= 3'h0;
		chk(h, `SMC_HOLD_CYC, "core hold");
		wb(1, `SMC_ADR_POWER_CTRL, 32'h0, 4'h1);
	endtask

	task close_out;
		$display("counts: %0d compares, %0d errors", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		$display("ERROR %0t watchdog expired", $time);
		close_out;
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		// ************************************************************
		// Registers
		// ************************************************************
		wb(0, `SMC_ADR_POWER_CTRL, 0, 4'hf);
		chk(rd, 32'h0, "ctrl reset");
		wb(0, `SMC_ADR_STATUS, 0, 4'hf);
		chk(rd[3:0], 4'h1, "status run");
		wb(0, 8'h08, 0, 4'hf);
		chk(rd, 32'h0, "unmapped read");
		na = $random(seed);
		wb(1, `SMC_ADR_POWER_CTRL, na, 4'h1);
		wb(1, `SMC_ADR_POWER_CTRL, ~na, 4'h0);
		wb(0, `SMC_ADR_POWER_CTRL, 0, 4'hf);
		chk(rd, {24'h0, na[7:0]}, "ctrl readback");
		wb(1, `SMC_ADR_STATUS, 32'hff, 4'hf);
		wb(0, `SMC_ADR_STATUS, 0, 4'hf);
		chk(rd[3:0], 4'h1, "status read only");
		$display("test registers done");
		// ************************************************************
		// Every mode code, entry, blocked sources, wake timing
		// ************************************************************
		for (int m = 0; m < 8; m++) begin
			asy <= (m == 3) | 1'($random(seed));
			cks <= 4'h9 + 4'($unsigned($random(seed)) % 7);
			na = n_adc;
			sleep_in(m[2:0], 1'b1);
			chk(clk_en, exp_clk(m[2:0], asy), "mode clocks");
			chk(n_adc - na, 32'(m < 2), "auto start");
			if (m == 4 || m == 5) begin
				wb(1, `SMC_ADR_POWER_CTRL, 32'h0, 4'h1);
				continue;
			end
			if (m != 0) begin
				wake <= smc_wake_t'(m == 1 ? 8'h01 : 8'h07);
				repeat (10) @(posedge ref_clk);
				chk(clk_en.core_clock, 0, "blocked source");
			end
			wake <= smc_wake_t'(8'h10);
			meas();
			if (m == 0) base = d;
			if (m >= 6) chk(d, base + 6, "standby wake");
			if (m == 2 || m == 3) chk(d, base + 1024, "xtal start");
		end
		$display("test modes done");
		// ************************************************************
		// Refusals
		// ************************************************************
		sleep_in(3'h2, 1'b0);
		chk(clk_en[6:1], 6'h3f, "arm clear");
		cks <= 4'h5;
		sleep_in(3'h6, 1'b1);
		chk(clk_en[6:1], 6'h3f, "standby no xtal");
		wb(1, `SMC_ADR_POWER_CTRL, 32'h0, 4'h1);
		$display("test refusals done");
		// ************************************************************
		// RC start-up, async timer, level pin, reset wake
		// ************************************************************
		for (int s = 0; s < 4; s += 3) begin
			sut <= 2'(s);
			sleep_in(3'h2, 1'b1);
			wake <= smc_wake_t'(8'h10);
			meas();
			chk(d, base + (s == 3 ? 6 : 18), "rc start");
		end
		asy <= 1'b1;
		gie <= 1'b0;
		sleep_in(3'h3, 1'b1);
		wake <= smc_wake_t'(8'h08);
		repeat (10) @(posedge ref_clk);
		chk(clk_en.core_clock, 0, "timer gated");
		gie <= 1'b1;
		meas();
		sleep_in(3'h2, 1'b1);
		pen <= 3'h1;
		pin <= 3'h6; // held low until the wake is seen
		meas();
		chk(d < 100, 1, "level wake");
		sleep_in(3'h2, 1'b1);
		na = resumes;
		reset_req <= 1'b1;
		n = 0;
		while (restart_vector !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		reset_req <= 1'b0;
		chk(restart_vector, 1, "reset wake");
		chk(resumes, na, "no resume on reset");
		wb(0, `SMC_ADR_STATUS, 0, 4'hf);
		chk(rd, 32'h000000a1, "status after reset wake");
		$display("test wake sources done");
		close_out;
	end
endmodule
